// ===== hdl/standby_keep_pkg.sv
// Package for the standby keep-alive control bank: register offsets, field positions,
// reset values and the widths of the per-channel, per-setup and per-pin settings.
// Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
package standby_keep_pkg;
    // Register byte addresses (one aligned 32-bit word each).
    localparam logic [3:0] keep_control_offset = 4'h0;
    localparam logic [3:0] aux_settings_offset = 4'h4;
    localparam logic [3:0] setup_settings_offset = 4'h8;
    localparam logic [3:0] channel_settings_offset = 4'hc;
    // Bit positions inside the keep-alive register.
    localparam int open_wire_bit = 1;
    localparam int excitation_bit = 2;
    localparam int bias_bit = 3;
    localparam int power_switch_bit = 5;
    localparam int general_outputs_bit = 6;
    localparam int diag_bit = 7;
    // Reset value of the keep-alive register; every keep bit starts at 0.
    localparam logic [15:0] keep_control_reset = 16'h0000;
    // Reset value of the auxiliary settings words.
    localparam logic [31:0] settings_reset = 32'h0000_0000;
    // Number of setups, channels, bias pins and general outputs.
    localparam int num_setups = 4;
    localparam int num_channels = 4;
    localparam int num_bias_pins = 8;
    localparam int num_outputs = 4;
    // Width of an excitation magnitude code and of a routing index.
    localparam int level_width = 3;
    localparam int route_width = 2;
    // Fields of the auxiliary settings word.
    localparam int aux_bias_lsb = 0;
    localparam int aux_outputs_lsb = 8;
    localparam int aux_diag_bit = 12;
    localparam int aux_osc_checks_bit = 13;
    localparam int aux_internal_osc_bit = 14;
    // Fields of one setup byte inside the setup settings word.
    localparam int setup_open_wire_bit = 0;
    localparam int setup_level_a_lsb = 1;
    localparam int setup_level_b_lsb = 4;
    // Fields of one channel byte inside the channel settings word.
    localparam int chan_switch_bit = 0;
    localparam int chan_setup_lsb = 1;
    localparam int chan_route_a_lsb = 3;
    localparam int chan_route_b_lsb = 5;
    // Bus answer latency: one wait state for every access.
    localparam int bus_wait_cycles = 1;
endpackage : standby_keep_pkg

// ===== hdl/keep_gate.sv
// Gate for one group of auxiliary enables under the standby keep-alive policy.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/1ns
module keep_gate #(
    parameter int width = 1
) (
    input wire logic standby,
    input wire logic keep,
    input wire logic [width-1:0] normal_enable,
    output logic [width-1:0] gated_enable
);
    // A zero-width group would leave nothing to gate.
    if (width < 1) begin : g_width_check
        $error("Gate width must be at least 1.");
    end

    // While converting the normal enables pass untouched; in standby the keep
    // bit decides whether the normal enables still apply or all go off.
    assign gated_enable = (!standby || keep) ? normal_enable : '0;
endmodule : keep_gate

// ===== hdl/standby_keep_alive_control.sv
// Standby keep-alive control bank with its Avalon-MM slave and the gating of the
// auxiliary functions: diagnostics, general outputs, power switch, open-wire
// current, bias voltage, excitation currents and the internal oscillator.
// Assumes the standby level arrives from another domain and is synchronised here.
// Assumes software writes each setting before it relies on the gated output.
`timescale 1ns/1ns
module standby_keep_alive_control
#(
    parameter int setups = standby_keep_pkg::num_setups,
    parameter int channels = standby_keep_pkg::num_channels
) (
    // Clock and synchronous reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave port for the register bank.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Standby level from the power sequencer, asynchronous.
    input wire logic standby_pin,
    // Gated enables of the auxiliary functions, plus the ungated excitation levels and routes.
    output logic diag_active,
    output logic [standby_keep_pkg::num_outputs-1:0] general_output,
    output logic [standby_keep_pkg::num_channels-1:0] low_side_power_switch,
    output logic [standby_keep_pkg::num_channels-1:0] open_wire_current,
    output logic [standby_keep_pkg::num_bias_pins-1:0] bias_voltage_enables,
    output logic [standby_keep_pkg::num_channels-1:0] excitation_a_on,
    output logic [standby_keep_pkg::num_channels-1:0] excitation_b_on,
    output logic [standby_keep_pkg::num_channels*standby_keep_pkg::level_width-1:0]
        excitation_a_level,
    output logic [standby_keep_pkg::num_channels*standby_keep_pkg::level_width-1:0]
        excitation_b_level,
    output logic [standby_keep_pkg::num_channels*standby_keep_pkg::route_width-1:0]
        excitation_a_route,
    output logic [standby_keep_pkg::num_channels*standby_keep_pkg::route_width-1:0]
        excitation_b_route,
    output logic oscillator_run
);
    import standby_keep_pkg::*;

    // The packed settings words hold one byte per setup and per channel.
    // Other counts would shift fields across the byte lanes.
    if (setups != num_setups || channels != num_channels) begin : g_size_check
        $error("Setup and channel counts must match the packed settings words.");
    end

    // Returns one byte lane of a settings word.
    // Lane idx holds the byte of setup or channel idx.
    function automatic logic [7:0] lane(input logic [31:0] word, input int idx);
        lane = word[idx*8 +: 8];
    endfunction : lane

    // Merges a bus write into a word under the byte enables.
    // Lanes whose enable is low keep their old contents.
    function automatic logic [31:0] merge(input logic [31:0] old_word,
                                          input logic [31:0] new_word,
                                          input logic [3:0] enables);
        logic [31:0] result;

        result = old_word;
        for (int b = 0; b < 4; b++) begin
            if (enables[b]) begin
                result[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        merge = result;
    endfunction : merge

    // Two-stage synchroniser for the standby level from the power sequencer.
    logic standby_meta_q; // First stage, read only by the second stage.
    logic standby_q; // Synchronised standby level.

    // Register bank.
    logic [15:0] standby_misc_control_q; // Keep-alive bits.
    logic [15:0] standby_misc_control_d;

    logic [31:0] aux_settings_q; // Bias pins, outputs, diagnostics, clock choice.
    logic [31:0] aux_settings_d;

    logic [31:0] setup_settings_q; // One byte per setup.
    logic [31:0] setup_settings_d;

    logic [31:0] channel_settings_q; // One byte per channel.
    logic [31:0] channel_settings_d;

    // Bus handshake state: a request is answered on the edge after it is seen.
    // It also keeps a request still held in the answer cycle from being taken twice.
    logic answer_q; // High for the one cycle that waitrequest is low.
    // Read data, registered so it stands in the answer cycle only.
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    // Response code, registered with the read data.
    logic [1:0] response_q;
    logic [1:0] response_d;

    // Address decode.
    wire access_req = (avs_read || avs_write) && !answer_q;

    // One hit per mapped word; any other address is a decode error.
    wire hit_keep = avs_address == keep_control_offset;
    wire hit_aux = avs_address == aux_settings_offset;
    wire hit_setup = avs_address == setup_settings_offset;
    wire hit_chan = avs_address == channel_settings_offset;
    wire hit_any = hit_keep || hit_aux || hit_setup || hit_chan;

    // A write lands at the answer edge, the one at which the master sees
    // waitrequest low, so a master that gives up earlier changes nothing.
    wire do_write = answer_q && avs_write;
    wire [31:0] keep_word = {16'h0000, standby_misc_control_q};

    // Write data for each register; the keep register ignores its upper lanes.
    wire [31:0] keep_merged = merge(keep_word, avs_writedata, avs_byteenable);
    // Only the low two lanes of the keep word are storage.
    assign standby_misc_control_d = (do_write && hit_keep) ?
        keep_merged[15:0] : standby_misc_control_q;

    assign aux_settings_d = (do_write && hit_aux) ?
        merge(aux_settings_q, avs_writedata, avs_byteenable) : aux_settings_q;

    assign setup_settings_d = (do_write && hit_setup) ?
        merge(setup_settings_q, avs_writedata, avs_byteenable) : setup_settings_q;

    assign channel_settings_d = (do_write && hit_chan) ?
        merge(channel_settings_q, avs_writedata, avs_byteenable) : channel_settings_q;

    // Read mux; an unmapped address answers zero with a decode error response.
    assign readdata_d = !(access_req && avs_read) ? 32'h0000_0000 :
                        hit_keep ? keep_word :
                        hit_aux ? aux_settings_q :
                        hit_setup ? setup_settings_q :
                        hit_chan ? channel_settings_q : 32'h0000_0000;

    // Unmapped words answer with a decode error, read or write alike.
    assign response_d = (access_req && !hit_any) ? 2'h3 : 2'h0;

    // Standby synchroniser; two flops before anything reads the level.
    // The first stage may go metastable, so only the second stage reads it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            standby_meta_q <= 1'b0;
            standby_q <= 1'b0;
        end else begin
            standby_meta_q <= standby_pin;
            standby_q <= standby_meta_q;
        end
    end

    // Register storage and bus answer.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Every setting starts cleared, so each keep bit reads 0.
            standby_misc_control_q <= keep_control_reset;
            aux_settings_q <= settings_reset;
            setup_settings_q <= settings_reset;
            channel_settings_q <= settings_reset;

            // No answer pending, waitrequest high.
            avs_waitrequest <= 1'b1;
            answer_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
            response_q <= 2'h0;
        end else begin
            standby_misc_control_q <= standby_misc_control_d;
            aux_settings_q <= aux_settings_d;
            setup_settings_q <= setup_settings_d;
            channel_settings_q <= channel_settings_d;

            // Bus answer for a request taken at this edge.
            avs_waitrequest <= !access_req;
            answer_q <= access_req;
            readdata_q <= readdata_d;
            response_q <= response_d;
        end
    end

    // Waitrequest, registered above, is low only in the answer cycle: one wait state.
    assign avs_readdata = readdata_q;
    assign avs_response = response_q;

    // Keep bits by name.
    // Bits 0 and 4 are stored and read back but drive nothing here.
    wire keep_open_wire = standby_misc_control_q[open_wire_bit];
    wire keep_excitation = standby_misc_control_q[excitation_bit];
    wire keep_bias = standby_misc_control_q[bias_bit];
    wire keep_switch = standby_misc_control_q[power_switch_bit];
    wire keep_outputs = standby_misc_control_q[general_outputs_bit];
    wire keep_diag = standby_misc_control_q[diag_bit];

    // Normal enables from the settings registers, per channel through its setup, the switch from the channel byte.
    logic [num_channels-1:0] norm_switch;
    logic [num_channels-1:0] norm_open_wire;
    logic [num_channels-1:0] norm_exc_a;
    logic [num_channels-1:0] norm_exc_b;

    // Excitation levels and routes per channel, never gated.
    logic [num_channels*level_width-1:0] level_a_d;
    logic [num_channels*level_width-1:0] level_b_d;
    logic [num_channels*route_width-1:0] route_a_d;
    logic [num_channels*route_width-1:0] route_b_d;

    for (genvar c = 0; c < num_channels; c++) begin : g_chan
        wire [7:0] chan_byte = lane(channel_settings_q, c);
        wire [1:0] setup_idx = chan_byte[chan_setup_lsb +: 2];
        wire [7:0] setup_byte = lane(setup_settings_q, int'(setup_idx));
        wire [level_width-1:0] lvl_a = setup_byte[setup_level_a_lsb +: level_width];
        wire [level_width-1:0] lvl_b = setup_byte[setup_level_b_lsb +: level_width];
        // The switch setting lives in the channel byte itself.
        assign norm_switch[c] = chan_byte[chan_switch_bit];
        // Open-wire and excitation settings come from the chosen setup.
        assign norm_open_wire[c] = setup_byte[setup_open_wire_bit];
        // A zero level code means the source is off.
        assign norm_exc_a[c] = lvl_a != '0;
        assign norm_exc_b[c] = lvl_b != '0;
        assign level_a_d[c*level_width +: level_width] = lvl_a;
        assign level_b_d[c*level_width +: level_width] = lvl_b;
        // Routes pass unchanged; they matter only while a source is on.
        assign route_a_d[c*route_width +: route_width] = chan_byte[chan_route_a_lsb +: 2];
        assign route_b_d[c*route_width +: route_width] = chan_byte[chan_route_b_lsb +: 2];
    end

    // Gated enables for each auxiliary group.
    // The two excitation groups share one keep bit.
    logic [0:0] diag_d;
    logic [num_outputs-1:0] outputs_d;
    logic [num_channels-1:0] switch_d;
    logic [num_channels-1:0] open_wire_d;
    logic [num_bias_pins-1:0] bias_d;
    logic [num_channels-1:0] exc_a_d;
    logic [num_channels-1:0] exc_b_d;


    // Diagnostics: gone in standby unless kept.
    keep_gate #(.width(1)) u_diag (
        .standby(standby_q),
        .keep(keep_diag),
        .normal_enable(aux_settings_q[aux_diag_bit]),
        .gated_enable(diag_d)
    );

    // General outputs: undriven in standby unless kept.
    keep_gate #(.width(num_outputs)) u_outputs (
        .standby(standby_q),
        .keep(keep_outputs),
        .normal_enable(aux_settings_q[aux_outputs_lsb +: num_outputs]),
        .gated_enable(outputs_d)
    );

    // Power switch: open in standby unless kept.
    keep_gate #(.width(num_channels)) u_switch (
        .standby(standby_q),
        .keep(keep_switch),
        .normal_enable(norm_switch),
        .gated_enable(switch_d)
    );

    // Open-wire current: off in standby unless kept.
    keep_gate #(.width(num_channels)) u_open_wire (
        .standby(standby_q),
        .keep(keep_open_wire),
        .normal_enable(norm_open_wire),
        .gated_enable(open_wire_d)
    );

    // Bias voltage: off on every pin in standby unless kept.
    keep_gate #(.width(num_bias_pins)) u_bias (
        .standby(standby_q),
        .keep(keep_bias),
        .normal_enable(aux_settings_q[aux_bias_lsb +: num_bias_pins]),
        .gated_enable(bias_d)
    );

    // Excitation source a: off in standby unless kept.
    keep_gate #(.width(num_channels)) u_exc_a (
        .standby(standby_q),
        .keep(keep_excitation),
        .normal_enable(norm_exc_a),
        .gated_enable(exc_a_d)
    );

    // Excitation source b follows the same keep bit.
    keep_gate #(.width(num_channels)) u_exc_b (
        .standby(standby_q),
        .keep(keep_excitation),
        .normal_enable(norm_exc_b),
        .gated_enable(exc_b_d)
    );

    // The oscillator runs while converting; in standby only if the diag keep bit is
    // set, an oscillator-based check is enabled and the internal clock is chosen.
    // Keeping the oscillator costs current, so all three conditions must hold.
    wire osc_d = !standby_q || (keep_diag && aux_settings_q[aux_osc_checks_bit] &&
                 aux_settings_q[aux_internal_osc_bit]);

    // Output flops; every output leaves from a register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            diag_active <= 1'b0;
            general_output <= '0;
            low_side_power_switch <= '0;
            open_wire_current <= '0;
            bias_voltage_enables <= '0;
            excitation_a_on <= '0;
            excitation_b_on <= '0;
            excitation_a_level <= '0;
            excitation_b_level <= '0;
            excitation_a_route <= '0;
            excitation_b_route <= '0;
            // The oscillator runs in reset so the core keeps its clock.
            oscillator_run <= 1'b1;
        end else begin
            // Enables of every group, already gated for standby.
            diag_active <= diag_d[0];
            general_output <= outputs_d;
            low_side_power_switch <= switch_d;
            open_wire_current <= open_wire_d;
            bias_voltage_enables <= bias_d;
            excitation_a_on <= exc_a_d;
            excitation_b_on <= exc_b_d;
            // Levels and routes stay valid in standby so kept sources reach their pins.
            excitation_a_level <= level_a_d;
            excitation_b_level <= level_b_d;
            excitation_a_route <= route_a_d;
            excitation_b_route <= route_b_d;
            // The oscillator decision leaves through a flop like the rest.
            oscillator_run <= osc_d;
        end
    end
endmodule : standby_keep_alive_control

// ===== verification/standby_keep_alive_control_props.sv
// Checker for the standby keep-alive bank: bus answer timing and excitation gating.
// Assumes it is bound to the bank's top module and sees only that module's ports.
`timescale 1ns/1ns
module standby_keep_alive_control_props (
    input logic sys_clk,
    input logic rst,
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic [1:0] avs_response,
    input logic standby_pin,
    input logic [3:0] excitation_a_on,
    input logic [3:0] excitation_b_on,
    input logic [11:0] excitation_a_level,
    input logic [11:0] excitation_b_level,
    input logic oscillator_run
);
    logic [3:0] a_nonzero; // Channels whose level a code is not off.
    logic [3:0] b_nonzero; // Channels whose level b code is not off.
    // A channel may only carry current when its level code selects one.
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            a_nonzero[c] = |excitation_a_level[c*3 +: 3];
            b_nonzero[c] = |excitation_b_level[c*3 +: 3];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_answer_next;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer_next: assert property (p_answer_next) else $error("Answer not one cycle late.");
    property p_answer_single;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_answer_single: assert property (p_answer_single) else $error("Answer held too long.");
    property p_no_spurious;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("Answer without request.");
    property p_idle_readdata;
        avs_waitrequest |-> avs_readdata == 32'h0;
    endproperty
    a_idle_readdata: assert property (p_idle_readdata) else $error("Read data outside answer.");
    property p_mapped_ok;
        !avs_waitrequest && avs_address[1:0] == 2'h0 |-> avs_response == 2'h0;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("Mapped access not answered OK.");
    property p_unmapped_err;
        !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_response == 2'h3 && avs_readdata == 0;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped access not refused.");
    property p_osc_converting;
        (!standby_pin) [*5] |-> oscillator_run;
    endproperty
    a_osc_converting: assert property (p_osc_converting) else $error("Oscillator off.") ;
    property p_exc_needs_level;
        ((excitation_a_on & ~a_nonzero) | (excitation_b_on & ~b_nonzero)) == 4'h0;
    endproperty
    a_exc_needs_level: assert property (p_exc_needs_level) else $error("Current at level off.");
    property p_exc_converting;
        (!standby_pin) [*5] |-> excitation_a_on == a_nonzero && excitation_b_on == b_nonzero;
    endproperty
    a_exc_converting: assert property (p_exc_converting) else $error("Excitation gated.");
endmodule : standby_keep_alive_control_props
bind standby_keep_alive_control standby_keep_alive_control_props standby_keep_alive_control_props_i (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .standby_pin(standby_pin), .excitation_a_on(excitation_a_on),
    .excitation_b_on(excitation_b_on), .excitation_a_level(excitation_a_level),
    .excitation_b_level(excitation_b_level), .oscillator_run(oscillator_run));

// ===== verification/standby_keep_alive_control_test.sv
// Testbench for the standby keep-alive bank: register access over Avalon-MM and the
// gating of every auxiliary output, in standby and while converting.
// Assumes the package constants and a slave that answers every request in time.
`timescale 1ns/1ns
module standby_keep_alive_control_test;
    import standby_keep_pkg::*;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, standby_pin, diag_active;
    logic oscillator_run;
    logic [3:0] avs_address, avs_byteenable, general_output, low_side_power_switch;
    logic [3:0] open_wire_current, excitation_a_on, excitation_b_on;
    logic [31:0] avs_writedata, avs_readdata, aux_v, rd;
    logic [1:0] avs_response, resp;
    logic [7:0] bias_voltage_enables, excitation_a_route, excitation_b_route;
    logic [11:0] excitation_a_level, excitation_b_level;
    int err_count;
    int cmp_count;
    // Keep words swept in standby: all groups, none, then each group alone.
    logic [7:0] modes [8] = '{8'hee, 8'h00, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80};
    standby_keep_alive_control standby_keep_alive_control_i (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .standby_pin(standby_pin), .diag_active(diag_active),
        .general_output(general_output), .low_side_power_switch(low_side_power_switch),
        .open_wire_current(open_wire_current), .bias_voltage_enables(bias_voltage_enables),
        .excitation_a_on(excitation_a_on), .excitation_b_on(excitation_b_on),
        .excitation_a_level(excitation_a_level), .excitation_b_level(excitation_b_level),
        .excitation_a_route(excitation_a_route), .excitation_b_route(excitation_b_route),
        .oscillator_run(oscillator_run));
    // Free-running system clock, 40 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // Compares one value; case inequality lets no unknown pass.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // One bus access; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        resp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check("bus wait", 32'(bus_wait_cycles), 32'(n - 1));
    endtask : bus
    // Lets the synchroniser and the output flops catch up.
    task automatic settle;
        repeat (5) @(posedge sys_clk);
    endtask : settle
    // Expected outputs for the fixed settings; a group is on when converting or kept.
    task automatic check_all(input logic [7:0] keep, input logic stby);
        logic [7:0] g;
        g = stby ? keep : 8'hff;
        check("diag", 32'(aux_v[12] & g[7]), 32'(diag_active));
        check("outputs", 32'(aux_v[11:8] & {4{g[6]}}), 32'(general_output));
        check("switch", 32'(4'hd & {4{g[5]}}), 32'(low_side_power_switch));
        check("open wire", 32'(4'h5 & {4{g[1]}}), 32'(open_wire_current));
        check("bias", 32'(aux_v[7:0] & {8{g[3]}}), 32'(bias_voltage_enables));
        check("exc on", 32'(8'h35 & {8{g[2]}}), 32'({excitation_b_on, excitation_a_on}));
        check("exc level", 32'h0001_51c3, {8'h0, excitation_b_level, excitation_a_level});
        check("exc route", 32'h0000_8dd2, {16'h0, excitation_b_route, excitation_a_route});
        check("osc", 32'(!stby | (keep[7] & aux_v[13] & aux_v[14])), 32'(oscillator_run));
    endtask : check_all
    // A hang ends the run as a failure.
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        stop_test;
    end
    // Main sequence: reset values, settings, keep sweep in standby, bus refusals.
    initial begin
        err_count = 0;
        cmp_count = 0;
        aux_v = 32'h0000_79a5;
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        standby_pin = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        check("osc reset", 32'h1, 32'(oscillator_run));
        bus(1'b0, keep_control_offset, 32'h0);
        check("keep reset", {16'h0, keep_control_reset}, rd);
        bus(1'b1, aux_settings_offset, aux_v);
        bus(1'b1, setup_settings_offset, 32'h0f00_2057);
        bus(1'b1, channel_settings_offset, 32'h5d0f_6231);
        bus(1'b1, keep_control_offset, 32'habcd_00ee);
        bus(1'b0, keep_control_offset, 32'h0);
        check("keep", 32'h0000_00ee, rd);
        settle;
        check_all(8'hee, 1'b0);
        standby_pin <= 1'b1;
        foreach (modes[i]) begin
            bus(1'b1, keep_control_offset, {24'h0, modes[i]});
            settle;
            check_all(modes[i], 1'b1);
        end
        // Without the oscillator-based check the oscillator may stop.
        aux_v = 32'h0000_59a5;
        bus(1'b1, aux_settings_offset, aux_v);
        settle;
        check_all(8'h80, 1'b1);
        standby_pin <= 1'b0;
        settle;
        check_all(8'h80, 1'b0);
        bus(1'b0, aux_settings_offset, 32'h0);
        check("aux", aux_v, rd);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped resp", 32'h3, 32'(resp));
        check("unmapped data", 32'h0, rd);
        bus(1'b0, keep_control_offset, 32'h0);
        check("keep kept", 32'h0000_0080, rd);
        stop_test;
    end
endmodule : standby_keep_alive_control_test
